// File: verilog/uart_emu_pkg.sv
// Constants shared by the UART emulation channel engine.
// Assumes a word-indexed register port; byte address is four times the index.
package uart_emu_pkg;
  // ==========================================================================
  // Register indices
  localparam logic [5:0] IDX_MODE   = 6'h00;
  localparam logic [5:0] IDX_CMD    = 6'h01;
  localparam logic [5:0] IDX_MAXIDL = 6'h02;
  localparam logic [5:0] IDX_IDLE_DOWN_COUNTER   = 6'h03;
  localparam logic [5:0] IDX_BRKCNT = 6'h04;
  localparam logic [5:0] IDX_BRKERR = 6'h05;
  localparam logic [5:0] IDX_RCC    = 6'h06;
  localparam logic [5:0] IDX_EVENT  = 6'h07;
  localparam logic [5:0] IDX_CHAR0  = 6'h08;
  localparam int         NUM_CHARS  = 8;
  // ==========================================================================
  // Mode register fields
  localparam int MD_RX_SLOWDOWN_ENABLE = 0;
  localparam int MD_TX_SLOWDOWN_ENABLE = 1;
  localparam int MD_RXD  = 2;
  localparam int MD_TXD  = 6;
  localparam int MD_ENR  = 10;
  localparam int MD_ENT  = 11;
  localparam int MD_FRZ  = 12;
  localparam int DIV_W   = 4;
  // ==========================================================================
  // Control character entry fields
  localparam int CC_END = 15;
  localparam int CC_REJ = 14;
  localparam int CC_REA = 13;
  localparam int CC_INT = 12;
  // ==========================================================================
  // Event register bits (write one to clear)
  localparam int EV_RX  = 0;
  localparam int EV_TX  = 1;
  localparam int EV_CCR = 2;
  localparam int EV_BRK = 3;
  localparam int EV_W   = 4;
  // ==========================================================================
  // Command codes
  localparam logic [15:0] CMD_STOP    = 16'h0001;
  localparam logic [15:0] CMD_RESTART = 16'h0002;
  localparam logic [15:0] CMD_HUNT    = 16'h0003;
  localparam logic [15:0] ZERO16      = 16'h0000;
  localparam logic [15:0] ONE16       = 16'h0001;
endpackage : uart_emu_pkg

// File: verilog/uart_emu_engine.sv
// UART emulation channel engine: moves characters between buffer streams and
// the emulated PC-side FIFOs. Assumes FIFOs and buffer tables are outside and
// run on clk; the register port is a simple single-cycle strobe port.
`timescale 1ns/1ps
`default_nettype none
module uart_emu_engine
  import uart_emu_pkg::*;
#(
  parameter int BRG_DIV = 16
) (
  input  wire  logic        clk,
  input  wire  logic        sys_rst,
  input  wire  logic [5:0]  reg_addr,
  input  wire  logic [15:0] reg_wdata,
  input  wire  logic        reg_wr,
  input  wire  logic        reg_rd,
  output logic [15:0]       reg_rdata,
  input  wire  logic        pc_tx_valid,
  input  wire  logic [7:0]  pc_tx_data,
  output logic              pc_tx_pop,
  input  wire  logic        pc_break,
  output logic              pc_rx_push,
  output logic [7:0]        pc_rx_data,
  output logic              pc_rx_brk,
  input  wire  logic        pc_rx_full,
  input  wire  logic        txb_ready,
  input  wire  logic [7:0]  txb_data,
  input  wire  logic        txb_last,
  input  wire  logic        txb_intr,
  output logic              txb_take,
  output logic              rxb_wr,
  output logic [7:0]        rxb_data,
  input  wire  logic        rxb_intr,
  output logic              rxb_close,
  output logic              rxb_ctrl,
  output logic              rxb_idle,
  output logic              rxb_brk
);
  // ==========================================================================
  // Registers
  logic [15:0]      mode_ff, maxidl_ff, idle_down_counter_ff, brkcnt_ff, brkerr_ff;
  logic [15:0]      rcc_ff, brk_left_ff;
  logic [EV_W-1:0]  event_ff;
  logic [15:0]      cc_ff [NUM_CHARS];
  logic [15:0]      brg_ff;
  logic [DIV_W-1:0] txc_ff, rxc_ff;
  logic             stopped_ff, txact_ff, hunt_ff, open_ff, pbrk_ff, flow_on_ff;
  logic             push_ff, pushbrk_ff;
  logic [7:0]       push_data_ff;
  logic             brk_s1_ff, brk_s2_ff;

  function automatic logic [NUM_CHARS:0] cc_match(input logic [7:0] ch,
                                                  input logic [16*NUM_CHARS-1:0] tbl);
    logic alive;
    cc_match = '0;
    alive    = 1'b1;
    for (int i = 0; i < NUM_CHARS; i++) begin
      if (alive && tbl[16*i+CC_END]) begin
        alive = 1'b0;
      end else if (alive && tbl[16*i +: 8] == ch && !cc_match[NUM_CHARS]) begin
        cc_match[NUM_CHARS] = 1'b1;
        cc_match[i]         = tbl[16*i+CC_REJ];
      end
    end
  endfunction : cc_match

  // ==========================================================================
  // Decode
  wire wr_mode   = reg_wr && reg_addr == IDX_MODE;
  wire wr_cmd    = reg_wr && reg_addr == IDX_CMD;
  wire wr_maxidl = reg_wr && reg_addr == IDX_MAXIDL;
  wire wr_brkcnt = reg_wr && reg_addr == IDX_BRKCNT;
  wire wr_brkerr = reg_wr && reg_addr == IDX_BRKERR;
  wire wr_event  = reg_wr && reg_addr == IDX_EVENT;
  wire cmd_stop  = wr_cmd && reg_wdata == CMD_STOP;
  wire cmd_rest  = wr_cmd && reg_wdata == CMD_RESTART;
  wire cmd_hunt  = wr_cmd && reg_wdata == CMD_HUNT;
  wire [2:0] cc_sel = reg_addr[2:0];
  wire wr_cc     = reg_wr && reg_addr[5:3] == IDX_CHAR0[5:3];
  wire ent  = mode_ff[MD_ENT];
  wire enr  = mode_ff[MD_ENR];
  wire tx_slowdown_enable = mode_ff[MD_TX_SLOWDOWN_ENABLE];
  wire rx_slowdown_enable = mode_ff[MD_RX_SLOWDOWN_ENABLE];
  wire frz  = mode_ff[MD_FRZ];

  // ==========================================================================
  // Dividers
  wire brg_tick = brg_ff == 16'(BRG_DIV - 1);
  wire tx_tmo   = brg_tick && txc_ff == '0;
  wire rx_tmo   = brg_tick && rxc_ff == '0;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      brg_ff <= '0;
      txc_ff <= '0;
      rxc_ff <= '0;
    end else begin
      brg_ff <= brg_tick ? '0 : brg_ff + ONE16;
      if (brg_tick) begin
        txc_ff <= tx_tmo ? mode_ff[MD_TXD +: DIV_W] : txc_ff - 1'b1;
        rxc_ff <= rx_tmo ? mode_ff[MD_RXD +: DIV_W] : rxc_ff - 1'b1;
      end
    end
  end

  // ==========================================================================
  // Transmit toward PC receive FIFO
  wire [15:0] flow_e   = cc_ff[NUM_CHARS-1];
  wire flow_cfg   = flow_e[CC_END] && !flow_e[CC_REJ];
  wire load_slot  = ent && !pc_rx_full && !push_ff && (!rx_slowdown_enable || rx_tmo);
  wire send_brk   = load_slot && brk_left_ff != ZERO16;
  wire send_flow  = load_slot && !send_brk && flow_cfg && flow_e[CC_REA] && !flow_on_ff;
  wire buf_ok     = txb_ready && (rx_slowdown_enable || txact_ff);
  wire send_buf   = load_slot && !send_brk && !send_flow && !stopped_ff && !frz && buf_ok;
  assign txb_take = send_buf;
  assign pc_rx_push = push_ff;
  assign pc_rx_data = push_data_ff;
  assign pc_rx_brk  = pushbrk_ff;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      push_ff      <= 1'b0;
      pushbrk_ff   <= 1'b0;
      push_data_ff <= '0;
      brk_left_ff  <= '0;
      stopped_ff   <= 1'b0;
      txact_ff     <= 1'b0;
      flow_on_ff   <= 1'b0;
    end else begin
      push_ff    <= send_brk || send_flow || send_buf;
      pushbrk_ff <= send_brk;
      if (send_brk) begin
        push_data_ff <= '0;
      end else if (send_flow) begin
        push_data_ff <= flow_e[7:0];
      end else if (send_buf) begin
        push_data_ff <= txb_data;
      end
      if (cmd_stop) begin
        brk_left_ff <= brkcnt_ff;
      end else if (send_brk) begin
        brk_left_ff <= brk_left_ff - ONE16;
      end
      if (cmd_rest) begin
        stopped_ff <= 1'b0;
      end else if (cmd_stop) begin
        stopped_ff <= 1'b1;
      end
      if (!ent || (send_buf && txb_last)) begin
        txact_ff <= 1'b0;
      end else if (tx_tmo && txb_ready) begin
        txact_ff <= 1'b1;
      end
      flow_on_ff <= send_flow;
    end
  end

  // ==========================================================================
  // Receive from PC transmit FIFO
  // transmit FIFO pacing
  wire poll      = enr && (!tx_slowdown_enable || tx_tmo);
  assign pc_tx_pop = poll && pc_tx_valid && !hunt_ff;
  wire idle_in   = enr && tx_tmo && !pc_tx_valid;
  logic [16*NUM_CHARS-1:0] cc_flat;
  always_comb begin
    for (int i = 0; i < NUM_CHARS; i++) begin
      cc_flat[16*i +: 16] = cc_ff[i];
    end
  end
  wire [NUM_CHARS:0] m = cc_match(pc_tx_data, cc_flat);
  wire rej       = m[NUM_CHARS] && |m[NUM_CHARS-1:0];
  wire ctl_keep  = m[NUM_CHARS] && !rej;
  wire brk_edge  = brk_s2_ff && !pbrk_ff;
  wire idle_done = idle_in && open_ff && idle_down_counter_ff == ONE16;
  wire brk_close = brk_edge && open_ff;
  wire hunt_close = cmd_hunt && open_ff;
  wire ctl_close = pc_tx_pop && ctl_keep;
  wire close_now = idle_done || brk_close || hunt_close || ctl_close;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rxb_wr    <= 1'b0;
      rxb_data  <= '0;
      rxb_close <= 1'b0;
      rxb_ctrl  <= 1'b0;
      rxb_idle  <= 1'b0;
      rxb_brk   <= 1'b0;
      open_ff   <= 1'b0;
      hunt_ff   <= 1'b0;
      idle_down_counter_ff   <= '0;
      pbrk_ff   <= 1'b0;
      brk_s1_ff <= 1'b0;
      brk_s2_ff <= 1'b0;
      rcc_ff    <= '0;
      brkerr_ff <= '0;
    end else begin
      // The break request comes from the PC side, so it passes two flops.
      brk_s1_ff <= pc_break;
      brk_s2_ff <= brk_s1_ff;
      pbrk_ff   <= brk_s2_ff;
      rxb_wr    <= pc_tx_pop && !rej;
      if (pc_tx_pop && !rej) begin
        rxb_data <= pc_tx_data;
      end
      rxb_close <= close_now;
      rxb_ctrl  <= ctl_close;
      rxb_idle  <= idle_done;
      rxb_brk   <= brk_close;
      if (close_now) begin
        open_ff <= 1'b0;
      end else if (pc_tx_pop && !rej) begin
        open_ff <= 1'b1;
      end
      if (cmd_hunt) begin
        hunt_ff <= 1'b1;
      end else if (idle_in) begin
        hunt_ff <= 1'b0;
      end
      if (pc_tx_pop && !rej) begin
        idle_down_counter_ff <= maxidl_ff;
      end else if (idle_in && open_ff) begin
        idle_down_counter_ff <= idle_down_counter_ff - ONE16;
      end
      if (pc_tx_pop && rej) begin
        rcc_ff <= {8'h00, pc_tx_data};
      end
      if (brk_edge) begin
        brkerr_ff <= brkerr_ff + ONE16;
      end else if (wr_brkerr) begin
        brkerr_ff <= reg_wdata;
      end
    end
  end

  // ==========================================================================
  // Events, mode, table and read port
  wire [EV_W-1:0] ev_set;
  assign ev_set[EV_RX]  = close_now && (rxb_intr || brk_close);
  assign ev_set[EV_TX]  = (flow_on_ff && flow_e[CC_INT]) || (send_buf && txb_last && txb_intr);
  assign ev_set[EV_CCR] = pc_tx_pop && rej;
  assign ev_set[EV_BRK] = brk_edge;

  logic [15:0] reg_rd_val;
  always_comb begin
    unique case (reg_addr)
      IDX_MODE:   reg_rd_val = mode_ff;
      IDX_MAXIDL: reg_rd_val = maxidl_ff;
      IDX_IDLE_DOWN_COUNTER:   reg_rd_val = idle_down_counter_ff;
      IDX_BRKCNT: reg_rd_val = brkcnt_ff;
      IDX_BRKERR: reg_rd_val = brkerr_ff;
      IDX_RCC:    reg_rd_val = rcc_ff;
      IDX_EVENT:  reg_rd_val = {12'h000, event_ff};
      default:    reg_rd_val = (reg_addr[5:3] == IDX_CHAR0[5:3]) ? cc_ff[cc_sel] : ZERO16;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_ff   <= '0;
      maxidl_ff <= '0;
      brkcnt_ff <= '0;
      event_ff  <= '0;
      reg_rdata <= '0;
      for (int i = 0; i < NUM_CHARS; i++) begin
        cc_ff[i] <= '0;
      end
    end else begin
      if (reg_rd) begin
        reg_rdata <= reg_rd_val;
      end
      if (wr_mode) begin
        mode_ff <= reg_wdata;
      end
      if (wr_maxidl) begin
        maxidl_ff <= reg_wdata;
      end
      if (wr_brkcnt) begin
        brkcnt_ff <= reg_wdata;
      end
      // Set wins over a same-cycle clear.
      event_ff <= (event_ff & ~(wr_event ? reg_wdata[EV_W-1:0] : '0)) | ev_set;
      for (int i = 0; i < NUM_CHARS; i++) begin
        if (wr_cc && cc_sel == 3'(i)) begin
          cc_ff[i] <= reg_wdata;
        end
      end
      if (flow_on_ff && !(wr_cc && cc_sel == 3'(NUM_CHARS - 1))) begin
        cc_ff[NUM_CHARS-1][CC_REA] <= 1'b0;
      end
    end
  end
endmodule : uart_emu_engine
`default_nettype wire

// File: testbench/uart_emu_asserts.sv
// Port checker for the UART emulation channel engine.
// Assumes it is bound to every instance of uart_emu_engine.
`timescale 1ns/1ps
`default_nettype none
module uart_emu_asserts (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       pc_tx_valid,
  input wire logic [7:0] pc_tx_data,
  input wire logic       pc_tx_pop,
  input wire logic       pc_rx_push,
  input wire logic [7:0] pc_rx_data,
  input wire logic       pc_rx_brk,
  input wire logic       pc_rx_full,
  input wire logic       txb_ready,
  input wire logic [7:0] txb_data,
  input wire logic       txb_take,
  input wire logic       rxb_wr,
  input wire logic [7:0] rxb_data,
  input wire logic       rxb_close,
  input wire logic       rxb_ctrl,
  input wire logic       rxb_idle,
  input wire logic       rxb_brk
);
  // ==========
  // Assertions
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_push_gap;
    pc_rx_push |=> !pc_rx_push;
  endproperty
  a_push_gap: assert property (p_push_gap) else $error("receive pushes too close");
  property p_pop_valid;
    pc_tx_pop |-> pc_tx_valid;
  endproperty
  a_pop_valid: assert property (p_pop_valid) else $error("pop from empty fifo");
  property p_take_push;
    txb_take |=> pc_rx_push && !pc_rx_brk && pc_rx_data == $past(txb_data);
  endproperty
  a_take_push: assert property (p_take_push) else $error("buffer char not pushed");
  property p_take_ok;
    txb_take |-> txb_ready && !pc_rx_full;
  endproperty
  a_take_ok: assert property (p_take_ok) else $error("take while not ready or full");
  property p_brk_zero;
    pc_rx_push && pc_rx_brk |-> pc_rx_data == 8'h00;
  endproperty
  a_brk_zero: assert property (p_brk_zero) else $error("break is not all zeros");
  property p_wr_src;
    rxb_wr |-> $past(pc_tx_pop) && rxb_data == $past(pc_tx_data);
  endproperty
  a_wr_src: assert property (p_wr_src) else $error("stored char not popped");
  property p_reason;
    rxb_ctrl || rxb_idle || rxb_brk |-> rxb_close;
  endproperty
  a_reason: assert property (p_reason) else $error("close reason without close");
  property p_ctrl_wr;
    rxb_ctrl |-> rxb_wr;
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr) else $error("control close without store");
endmodule : uart_emu_asserts
bind uart_emu_engine uart_emu_asserts chk_i (.clk, .sys_rst, .pc_tx_valid, .pc_tx_data,
  .pc_tx_pop, .pc_rx_push, .pc_rx_data, .pc_rx_brk, .pc_rx_full, .txb_ready, .txb_data,
  .txb_take, .rxb_wr, .rxb_data, .rxb_close, .rxb_ctrl, .rxb_idle, .rxb_brk);
`default_nettype wire

// File: testbench/pc_side_model.sv
// PC side model: transmit fifo towards the engine, collector of received items.
// Assumes the bench queues bytes with send after a clock edge and drives stall.
`timescale 1ns/1ps
`default_nettype none
module pc_side_model (
  input  wire logic       clk,
  input  wire logic       stall,
  input  wire logic       pc_tx_pop,
  input  wire logic       pc_rx_push,
  input  wire logic [7:0] pc_rx_data,
  input  wire logic       pc_rx_brk,
  output logic            pc_tx_valid,
  output logic [7:0]      pc_tx_data,
  output logic            pc_rx_full
);
  // ==========
  // Fifo state
  logic [7:0] tq[$];
  logic [8:0] rq[$];
  task automatic send(input logic [7:0] b);
    tq.push_back(b);
  endtask : send
  initial begin
    pc_tx_valid = 1'b0;
    pc_tx_data  = 8'h00;
    pc_rx_full  = 1'b0;
  end
  always @(posedge clk) begin
    if (pc_tx_pop)
      void'(tq.pop_front());
    pc_tx_valid <= tq.size() > 0;
    pc_tx_data  <= (tq.size() > 0) ? tq[0] : ~pc_tx_data;
    pc_rx_full  <= stall;
    if (pc_rx_push)
      rq.push_back({pc_rx_brk, pc_rx_data});
  end
endmodule : pc_side_model
`default_nettype wire

// File: testbench/testbench.sv
// Self-checking bench for the UART emulation channel engine.
// Assumes the PC side model and the bound checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import uart_emu_pkg::*;
  localparam int BRG     = 2;
  localparam int DIV_SET = 3;
  typedef struct packed {logic [5:0] a; logic [15:0] d; logic [15:0] e;} row_t;
  logic        clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, pc_break = 1'b0;
  logic        stall = 1'b0, txb_ready = 1'b0, txb_last = 1'b0;
  logic        txb_intr = 1'b0, rxb_intr = 1'b1;
  logic [5:0]  reg_addr = 6'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic [7:0]  txb_data = 8'h00, pc_tx_data, pc_rx_data, rxb_data;
  logic        pc_tx_valid, pc_tx_pop, pc_rx_push, pc_rx_brk, pc_rx_full, txb_take;
  logic        rxb_wr, rxb_close, rxb_ctrl, rxb_idle, rxb_brk;
  logic [7:0]  xq[$], wq[$];
  int          error_cnt = 0, check_count = 0, n_close = 0, n_idle = 0, n_brk = 0, n_ctrl = 0;
  int          cyc = 0, t_push = 0, t_wr = 0, gap_push = 0, gap_wr = 0;
  row_t        rows [8] = '{'{IDX_MAXIDL, 16'h0003, 16'h0003}, '{IDX_BRKCNT, 16'h0002, 16'h0002},
    '{IDX_CMD, 16'h0000, 16'h0000}, '{6'h3f, 16'hffff, 16'h0000}, '{IDX_RCC, 16'h00aa, 16'h0000},
    '{IDX_CHAR0, 16'h000d, 16'h000d}, '{IDX_CHAR0 + 6'h01, 16'h4011, 16'h4011},
    '{IDX_CHAR0 + 6'h02, 16'h8000, 16'h8000}};
  // ==========
  // Design and partner
  uart_emu_engine #(.BRG_DIV(BRG)) DUT (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .pc_tx_valid, .pc_tx_data, .pc_tx_pop, .pc_break, .pc_rx_push, .pc_rx_data,
    .pc_rx_brk, .pc_rx_full, .txb_ready, .txb_data, .txb_last, .txb_intr, .txb_take,
    .rxb_wr, .rxb_data, .rxb_intr, .rxb_close, .rxb_ctrl, .rxb_idle, .rxb_brk);
  pc_side_model PC (.clk, .stall, .pc_tx_pop, .pc_tx_valid, .pc_tx_data, .pc_rx_push,
    .pc_rx_data, .pc_rx_brk, .pc_rx_full);
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (pc_rx_push) begin
      gap_push = cyc - t_push;
      t_push   = cyc;
    end
    if (rxb_wr) begin
      gap_wr = cyc - t_wr;
      t_wr   = cyc;
      wq.push_back(rxb_data);
    end
    n_close += rxb_close;
    n_idle  += rxb_idle;
    n_brk   += rxb_brk;
    n_ctrl  += rxb_ctrl;
    if (txb_take)
      void'(xq.pop_front());
    txb_ready <= xq.size() > 0;
    txb_data  <= (xq.size() > 0) ? xq[0] : ~txb_data;
    txb_last  <= xq.size() == 1;
  end
  // ==========
  // Tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask : rd
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  task automatic tx(input logic [7:0] b[$]);
    @(posedge clk);
    #1 foreach (b[i]) PC.send(b[i]);
  endtask : tx
  task automatic exp_rx(input logic [8:0] e[$]);
    for (int i = 0; i < 600 && PC.rq.size() < e.size(); i++) @(posedge clk);
    #1 chk(16'(PC.rq.size()), 16'(e.size()));
    foreach (e[i]) chk({7'h00, PC.rq[i]}, {7'h00, e[i]});
    PC.rq.delete();
  endtask : exp_rx
  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict
  initial begin
    #(40 * 10000);
    error_cnt++;
    give_verdict();
  end
  // ==========
  // Main sequence
  initial begin
    wt(20);
    sys_rst <= 1'b0;
    rd(IDX_MODE, 16'h0000);
    rd(IDX_EVENT, 16'h0000);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    $display("Register table test done");
    wr(IDX_MODE, 16'h0c00);
    tx('{8'h41, 8'h11, 8'h42, 8'h0d});
    wt(200);
    chk({wq[0], wq[1]}, 16'h4142);
    chk({8'h00, wq[2]}, 16'h000d);
    chk(16'(n_ctrl), 16'h0001);
    rd(IDX_RCC, 16'h0011);
    tx('{8'h55});
    wt(200);
    chk(16'(n_idle), 16'h0001);
    chk(16'(n_close), 16'h0002);
    rd(IDX_EVENT, 16'h0005);
    wr(IDX_EVENT, 16'h000f);
    $display("Receive test done");
    @(posedge clk);
    #1 xq = '{8'hc1, 8'hc2, 8'hc3};
    stall <= 1'b1;
    wt(50);
    #1 chk(16'(PC.rq.size()), 16'h0000);
    stall <= 1'b0;
    exp_rx('{9'h0c1, 9'h0c2, 9'h0c3});
    wr(IDX_CMD, CMD_STOP);
    exp_rx('{9'h100, 9'h100});
    @(posedge clk);
    #1 xq = '{8'hd1};
    txb_intr <= 1'b1;
    wt(100);
    #1 chk(16'(PC.rq.size()), 16'h0000);
    wr(IDX_CMD, CMD_RESTART);
    exp_rx('{9'h0d1});
    rd(IDX_EVENT, 16'h0002);
    wr(IDX_EVENT, 16'h000f);
    wr(IDX_CHAR0 + 6'h07, 16'hb013);
    exp_rx('{9'h013});
    wt(4);
    rd(IDX_CHAR0 + 6'h07, 16'h9013);
    rd(IDX_EVENT, 16'h0002);
    wr(IDX_EVENT, 16'h000f);
    $display("Transmit test done");
    wr(IDX_MAXIDL, 16'h0000);
    tx('{8'h66});
    wt(10);
    pc_break <= 1'b1;
    wt(20);
    pc_break <= 1'b0;
    wt(10);
    chk(16'(n_brk), 16'h0001);
    rd(IDX_BRKERR, 16'h0001);
    rd(IDX_EVENT, 16'h0009);
    wr(IDX_EVENT, 16'h000f);
    rxb_intr <= 1'b0;
    tx('{8'h77});
    wt(10);
    wr(IDX_CMD, CMD_HUNT);
    wt(10);
    chk(16'(n_close), 16'h0004);
    rd(IDX_EVENT, 16'h0000);
    $display("Break and hunt test done");
    wr(IDX_MODE, 16'h0ccf);
    tx('{8'h21, 8'h22});
    @(posedge clk);
    #1 xq = '{8'he1, 8'he2};
    exp_rx('{9'h0e1, 9'h0e2});
    wt(20);
    #1 chk(16'(gap_push), 16'((DIV_SET + 1) * BRG));
    chk(16'(gap_wr), 16'((DIV_SET + 1) * BRG));
    $display("Slow-down test done");
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
